// ---- core/gat_pkg.sv ----
/*
 * gat_pkg: constants, register map and carrier types for the graphics
 * address translation block.
 * assumes: one 40 MHz clock, APB register access, memory port outside.
 */
// Operation
// R1 - translate logical address through 32-bit entries
// R2 - tables unsnooped; entry fetches never snoop
// R3 - software aligns table bases to 4KB
// R4 - global table 128/256/512KB, contiguous
// R5 - per-process table adds 64KB size
// R6 - global entries written through write window
// R7 - status posted by writes to 4KB page
// R8 - software sets status page address first
// R9 - ring buffers start 4KB aligned, linear
// R10 - ring buffer length at most 2MB
// R11 - batch fetches are unsnooped memory accesses
// R12 - batch start and length QWord multiples
// R13 - batch end addresses last valid QWord
// R14 - batch length up to full 4GB
// R15 - indirect primitives share vertex buffer space
// R16 - entry address base plus 4*page; bounds
package gat_pkg;
   // register byte offsets
   localparam logic [7:0] GAT_OFF_GLB_CTL    = 8'h00; // translation_table_control
   localparam logic [7:0] GAT_OFF_PPT_CTL    = 8'h04; // per_process_table_control
   localparam logic [7:0] GAT_OFF_STATUS_PG  = 8'h08; // status_page_address
   localparam logic [7:0] GAT_OFF_RING_BASE  = 8'h0C;
   localparam logic [7:0] GAT_OFF_RING_LEN   = 8'h10;
   localparam logic [7:0] GAT_OFF_BATCH_ST   = 8'h14;
   localparam logic [7:0] GAT_OFF_BATCH_END  = 8'h18;
   localparam logic [7:0] GAT_OFF_XLATE_ADDR = 8'h1C; // write starts a lookup
   localparam logic [7:0] GAT_OFF_XLATE_RES  = 8'h20;
   localparam logic [7:0] GAT_OFF_STATUS     = 8'h24;
   localparam logic [7:0] GAT_OFF_WIN_IDX    = 8'h28; // global_table_write_window index
   localparam logic [7:0] GAT_OFF_WIN_DATA   = 8'h2C; // write posts entry
   localparam logic [7:0] GAT_OFF_STAT_POST  = 8'h30; // write posts status dword
   // field positions
   localparam int GAT_CTL_SIZE_LSB = 1;   // size code bits [2:1]
   localparam int GAT_CTL_EN_BIT   = 0;
   localparam int GAT_PAGE_SHIFT   = 12;  // 4KB pages and alignment
   localparam int GAT_QW_SHIFT     = 3;
   localparam logic [31:0] GAT_RING_MAX = 32'h0020_0000; // 2MB
   // size codes: 0=128KB 1=256KB 2=512KB 3=64KB (per-process only)
   localparam logic [1:0] GAT_SZ_128 = 2'h0;
   localparam logic [1:0] GAT_SZ_256 = 2'h1;
   localparam logic [1:0] GAT_SZ_512 = 2'h2;
   localparam logic [1:0] GAT_SZ_64  = 2'h3;
   // table sizes in 4-byte entries
   localparam logic [19:0] GAT_NENT_64  = 20'h04000;
   localparam logic [19:0] GAT_NENT_128 = 20'h08000;
   localparam logic [19:0] GAT_NENT_256 = 20'h10000;
   localparam logic [19:0] GAT_NENT_512 = 20'h20000;
   // reset values
   localparam logic [31:0] GAT_RST_ZERO = 32'h0000_0000;
   // memory request kinds
   typedef enum logic [1:0] {GAT_MK_ENTRY_RD, GAT_MK_ENTRY_WR, GAT_MK_STATUS_WR} gat_kind_t;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        snoop;
      logic [31:0] addr;
      logic [31:0] wdata;
   } gat_mem_req_t;
   typedef struct packed {
      logic        valid;
      logic [31:0] rdata;
   } gat_mem_rsp_t;
endpackage

// ---- core/gat_xlate.sv ----
/*
 * gat_xlate: APB register file, table lookup engine, global table write
 * window, status page posting and buffer placement checks.
 * assumes: memory port answers each request with one rsp.valid pulse,
 * same clock; rsp inputs come from on-chip logic on pclk.
 */
`timescale 1ns/1ps
module gat_xlate
   import gat_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   output gat_mem_req_t      mem_req,
   input  wire gat_mem_rsp_t mem_rsp
);
   typedef enum {GAT_IDLE, GAT_REQ, GAT_WAIT} gat_state_t;

   logic [31:0]  gctl_reg, gctl_next, ppt_ctl_reg, ppt_ctl_next;
   logic [31:0]  stpg_reg, stpg_next, rbase_reg, rbase_next, rlen_reg, rlen_next;
   logic [31:0]  bst_reg, bst_next, bend_reg, bend_next, xaddr_reg, xaddr_next;
   logic [31:0]  xres_reg, xres_next, win_reg, win_next;
   logic [3:0]   flags_reg, flags_next; // busy,place_err,fault,done
   logic         use_ppt_reg, use_ppt_next;
   logic         bfetch_reg, bfetch_next; // outstanding request is a batch fetch
   gat_state_t   st_reg, st_next;
   gat_mem_req_t req_reg, req_next;
   logic [31:0]  prdata_next;
   logic         pready_next, pslverr_next;
   logic         acc, wr, busy;
   logic [1:0]   szc;
   logic [19:0]  nentries;
   logic [31:0]  tbase, page;
   logic         place_bad;

   assign acc  = psel & penable & ~pready;
   assign wr   = acc & pwrite;
   assign busy = (st_reg != GAT_IDLE);

   // table size in entries; global table cannot take the 64KB code
   always_comb begin
      szc = use_ppt_reg ? ppt_ctl_reg[GAT_CTL_SIZE_LSB +: 2] : gctl_reg[GAT_CTL_SIZE_LSB +: 2];
      case (szc)
         GAT_SZ_128: nentries = GAT_NENT_128; // R4
         GAT_SZ_256: nentries = GAT_NENT_256; // R4
         GAT_SZ_512: nentries = GAT_NENT_512; // R4
         GAT_SZ_64:  nentries = use_ppt_reg ? GAT_NENT_64 : GAT_NENT_128; // R5
         default:    nentries = GAT_NENT_128;
      endcase
      tbase = use_ppt_reg ? ppt_ctl_reg : gctl_reg;
      tbase[GAT_PAGE_SHIFT-1:0] = '0; // low bits are control fields, base stays 4KB aligned
      page  = {12'h000, xaddr_reg[31:GAT_PAGE_SHIFT]};
   end

   // placement checks: ring alignment and length, batch qword alignment
   always_comb begin
      place_bad = (rbase_reg[GAT_PAGE_SHIFT-1:0] != '0) // R9
               || (rlen_reg > GAT_RING_MAX)             // R10
               || (bst_reg[GAT_QW_SHIFT-1:0] != '0)    // R12
               || (bend_reg[GAT_QW_SHIFT-1:0] != '0)   // R13
               || (bend_reg < bst_reg);                 // R14 full 32-bit range allowed
   end

   // apb writes, lookup engine, memory master
   always_comb begin
      gctl_next    = gctl_reg;
      ppt_ctl_next = ppt_ctl_reg;
      stpg_next    = stpg_reg;
      rbase_next   = rbase_reg;
      rlen_next    = rlen_reg;
      bst_next     = bst_reg;
      bend_next    = bend_reg;
      xaddr_next   = xaddr_reg;
      xres_next    = xres_reg;
      win_next     = win_reg;
      flags_next   = flags_reg;
      use_ppt_next = use_ppt_reg;
      bfetch_next  = bfetch_reg;
      st_next      = st_reg;
      req_next     = req_reg;
      flags_next[2] = place_bad;
      if (wr && !busy) begin
         case (paddr)
            GAT_OFF_GLB_CTL:   gctl_next = pwdata;
            GAT_OFF_PPT_CTL:   ppt_ctl_next = pwdata;
            GAT_OFF_STATUS_PG: stpg_next = {pwdata[31:GAT_PAGE_SHIFT], 12'h000}; // R8
            GAT_OFF_RING_BASE: rbase_next = pwdata;
            GAT_OFF_RING_LEN:  rlen_next = pwdata;
            GAT_OFF_BATCH_ST:  bst_next = pwdata;
            GAT_OFF_BATCH_END: begin
               // end write launches the first qword fetch as main memory, never snooped
               bend_next   = pwdata;
               req_next    = '{1'b1, 1'b0, 1'b0, {bst_reg[31:GAT_QW_SHIFT], 3'b000}, GAT_RST_ZERO}; // R11 R12
               bfetch_next = 1'b1;
               st_next     = GAT_WAIT;
            end
            GAT_OFF_WIN_IDX:   win_next = pwdata;
            GAT_OFF_XLATE_ADDR: begin
               xaddr_next   = pwdata;
               use_ppt_next = ppt_ctl_reg[GAT_CTL_EN_BIT];
               flags_next[1:0] = 2'h0;
               st_next = GAT_REQ;
            end
            GAT_OFF_WIN_DATA: begin
               // global entries only through the window, unsnooped
               req_next = '{1'b1, 1'b1, 1'b0, {gctl_reg[31:GAT_PAGE_SHIFT], 12'h000} + {win_reg[29:0], 2'b00},
                            pwdata}; // R6 R2
               st_next = GAT_WAIT;
            end
            GAT_OFF_STAT_POST: begin
               // status lands in the snooped 4KB page, word index in low bits
               req_next = '{1'b1, 1'b1, 1'b1, stpg_reg | {20'h00000, win_reg[9:0], 2'b00},
                            pwdata}; // R7
               st_next = GAT_WAIT;
            end
            default: ;
         endcase
      end
      case (st_reg)
         GAT_IDLE: ;
         GAT_REQ: begin
            if (page >= {12'h000, nentries}) begin
               flags_next[1:0] = 2'h3; // R16 out of aperture
               st_next = GAT_IDLE;
            end else begin
               // entry fetch never snoops the cpu cache
               req_next = '{1'b1, 1'b0, 1'b0, tbase + {page[29:0], 2'b00}, GAT_RST_ZERO}; // R16 R2 R1
               st_next = GAT_WAIT;
            end
         end
         GAT_WAIT: begin
            req_next.valid = 1'b0;
            if (mem_rsp.valid) begin
               bfetch_next = 1'b0;
               // batch words are not decoded here, so they leave the lookup result alone
               if (!req_reg.write && !bfetch_reg) begin
                  // entry bit0 valid, upper bits physical page
                  xres_next = {mem_rsp.rdata[31:GAT_PAGE_SHIFT], xaddr_reg[GAT_PAGE_SHIFT-1:0]}; // R1
                  flags_next[1:0] = mem_rsp.rdata[0] ? 2'h1 : 2'h3;
               end
               st_next = GAT_IDLE;
            end
         end
         default: st_next = GAT_IDLE;
      endcase
      flags_next[3] = (st_next != GAT_IDLE);
   end

   // apb read data; writes while busy, except to the status offset, are refused with pslverr
   always_comb begin
      pready_next  = acc;
      pslverr_next = 1'b0;
      prdata_next  = GAT_RST_ZERO;
      if (acc) begin
         case (paddr)
            GAT_OFF_GLB_CTL:    prdata_next = gctl_reg;
            GAT_OFF_PPT_CTL:    prdata_next = ppt_ctl_reg;
            GAT_OFF_STATUS_PG:  prdata_next = stpg_reg;
            GAT_OFF_RING_BASE:  prdata_next = rbase_reg;
            GAT_OFF_RING_LEN:   prdata_next = rlen_reg;
            GAT_OFF_BATCH_ST:   prdata_next = bst_reg;
            GAT_OFF_BATCH_END:  prdata_next = bend_reg;
            GAT_OFF_XLATE_ADDR: prdata_next = xaddr_reg;
            GAT_OFF_XLATE_RES:  prdata_next = xres_reg;
            GAT_OFF_STATUS:     prdata_next = {28'h0000000, flags_reg};
            GAT_OFF_WIN_IDX:    prdata_next = win_reg;
            GAT_OFF_WIN_DATA, GAT_OFF_STAT_POST: prdata_next = GAT_RST_ZERO;
            default:            pslverr_next = 1'b1;
         endcase
         if (pwrite && busy && paddr != GAT_OFF_STATUS)
            pslverr_next = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gctl_reg    <= GAT_RST_ZERO;
         ppt_ctl_reg <= GAT_RST_ZERO;
         stpg_reg    <= GAT_RST_ZERO;
         rbase_reg   <= GAT_RST_ZERO;
         rlen_reg    <= GAT_RST_ZERO;
         bst_reg     <= GAT_RST_ZERO;
         bend_reg    <= GAT_RST_ZERO;
         xaddr_reg   <= GAT_RST_ZERO;
         xres_reg    <= GAT_RST_ZERO;
         win_reg     <= GAT_RST_ZERO;
         flags_reg   <= 4'h0;
         use_ppt_reg <= 1'b0;
         bfetch_reg  <= 1'b0;
         st_reg      <= GAT_IDLE;
         req_reg     <= '0;
         prdata      <= GAT_RST_ZERO;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
      end else begin
         gctl_reg    <= gctl_next;
         ppt_ctl_reg <= ppt_ctl_next;
         stpg_reg    <= stpg_next;
         rbase_reg   <= rbase_next;
         rlen_reg    <= rlen_next;
         bst_reg     <= bst_next;
         bend_reg    <= bend_next;
         xaddr_reg   <= xaddr_next;
         xres_reg    <= xres_next;
         win_reg     <= win_next;
         flags_reg   <= flags_next;
         use_ppt_reg <= use_ppt_next;
         bfetch_reg  <= bfetch_next;
         st_reg      <= st_next;
         req_reg     <= req_next;
         prdata      <= prdata_next;
         pready      <= pready_next;
         pslverr     <= pslverr_next;
      end
   end

   assign mem_req = req_reg;
endmodule

// ---- tb/gat_mem_model.sv ----
/* gat_mem_model: system memory behind the translation block's memory port.
   assumes: one request in flight, same clock as the block. */
`timescale 1ns/1ps
module gat_mem_model
   import gat_pkg::*;
(
   input  wire logic         pclk,
   input  wire logic         slow,
   input  wire gat_mem_req_t mem_req,
   output gat_mem_rsp_t      mem_rsp
);
   logic [31:0] mem [logic [31:0]]; // one flat space: commands and vertex data share it
   logic [31:0] rd;
   int          cnt = 0;
   initial mem_rsp = '0;
   // store writes, answer each request once, late when slow
   always @(posedge pclk) begin
      if (mem_req.valid === 1'b1) begin
         if (mem_req.write) mem[mem_req.addr] = mem_req.wdata;
         rd = mem.exists(mem_req.addr) ? mem[mem_req.addr] : 32'h0;
         cnt = slow ? 6 : 1;
      end
      if (cnt == 1) mem_rsp <= {1'b1, rd};
      else mem_rsp <= {1'b0, ~mem_rsp.rdata}; // old data must not look valid
      if (cnt > 0) cnt--;
   end
endmodule

// ---- tb/gat_xlate_props.sv ----
/* gat_xlate_props: port checks for gat_xlate.
   assumes: bound to every gat_xlate instance. */
`timescale 1ns/1ps
module gat_xlate_props
   import gat_pkg::*;
(
   input wire logic         pclk,
   input wire logic         presetn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic [7:0]   paddr,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire gat_mem_req_t mem_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // apb answer timing and refusals
   a_ready_follows: assert property (psel && penable && !pready |=> pready) else $error("access not answered");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h30 |-> pslverr)
      else $error("unmapped access not refused");
   // memory requests
   a_fetch_unsnooped: assert property (mem_req.valid && !mem_req.write |-> !mem_req.snoop)
      else $error("table fetch snooped");
   a_snoop_only_post: assert property (mem_req.valid && mem_req.snoop |-> mem_req.write)
      else $error("snooped request is not a write");
   a_req_aligned: assert property (mem_req.valid |-> mem_req.addr[1:0] == 2'h0)
      else $error("request address not word aligned");
   a_req_pulse: assert property (mem_req.valid |=> !mem_req.valid) else $error("request valid too long");
   a_req_hold: assert property (!mem_req.valid |-> $stable(mem_req.addr)) else $error("request address moved");
   c_fetch: cover property (mem_req.valid && !mem_req.write);
   c_post: cover property (mem_req.valid && mem_req.snoop);
   c_refuse: cover property (pslverr);
endmodule
bind gat_xlate gat_xlate_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
   .mem_req);

// ---- tb/tb.sv ----
/* tb: register-level tests of gat_xlate over apb.
   assumes: gat_mem_model stands on the memory port. */
`timescale 1ns/1ps
module tb
   import gat_pkg::*;
();
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0, prdata, r, st, ap;
   logic         pready, pslverr, e;
   gat_mem_req_t mem_req, lreq;
   gat_mem_rsp_t mem_rsp;
   int           num_errors = 0, num_checks = 0, nreq = 0, n0, cyc = 0;
   logic [31:0]  pt [6][5] = '{'{32'h1000, 32'h20_0000, 32'h8, 32'hFFFF_FFF8, 32'h0},
      '{32'h1800, 32'h1000, 32'h8, 32'h10, 32'h1}, '{32'h1000, 32'h20_0001, 32'h8, 32'h10, 32'h1},
      '{32'h1000, 32'h1000, 32'h4, 32'h10, 32'h1}, '{32'h1000, 32'h1000, 32'h10, 32'h8, 32'h1},
      '{32'h1000, 32'h1000, 32'h10, 32'h10, 32'h0}};
   gat_xlate dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .mem_req, .mem_rsp);
   gat_mem_model u_mem (.pclk, .slow, .mem_req, .mem_rsp);
   initial forever #12.5 pclk = ~pclk;
   // request capture and hang guard
   always @(posedge pclk) begin
      cyc++;
      if (mem_req.valid === 1'b1) lreq = mem_req;
      if (mem_req.valid === 1'b1) nreq++;
      if (cyc == 20000) num_errors++;
      if (cyc == 20000) print_verdict();
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, x);
      num_checks++;
      if (s !== x) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   // one transfer, request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), r, x);
   endtask
   task automatic look(input logic [31:0] l);
      apb(1'b1, 8'h1C, l);
      do apb(1'b0, 8'h24, 32'h0); while (r[3] !== 1'b0);
      st = r;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(8'h00, 32'h0);
      rdc(8'h24, 32'h0);
      apb(1'b1, 8'h08, 32'h0003_4567);
      rdc(8'h08, 32'h0003_4000);
      n0 = nreq;
      apb(1'b1, 8'h28, 32'h3);
      apb(1'b1, 8'h30, 32'hCAFE_0001);
      while (nreq == n0) @(posedge pclk);
      chk("post addr", lreq.addr, 32'h0003_400C);
      chk("post kind", {lreq.write, lreq.snoop}, 32'h3);
      chk("post data", lreq.wdata, 32'hCAFE_0001);
      apb(1'b1, 8'h00, 32'h0010_0004);
      n0 = nreq;
      apb(1'b1, 8'h28, 32'h5);
      apb(1'b1, 8'h2C, 32'h1234_5001);
      while (nreq == n0) @(posedge pclk);
      chk("win addr", lreq.addr, 32'h0010_0014);
      chk("win kind", {lreq.write, lreq.snoop}, 32'h2);
      chk("win data", lreq.wdata, 32'h1234_5001);
      look(32'h0000_5ABC);
      rdc(8'h20, 32'h1234_5ABC);
      chk("hit status", st, 32'h1);
      look(32'h0000_6000);
      chk("miss status", st, 32'h3);
      for (int c = 0; c < 3; c++) begin
         ap = 32'h0800_0000 << c;
         apb(1'b1, 8'h00, 32'h0010_0000 | (c << 1));
         n0 = nreq;
         look(ap - 32'h1000);
         chk("last entry", lreq.addr, 32'h0010_0000 + ((ap >> 12) - 1) * 4);
         look(ap);
         chk("aperture", nreq - n0, 32'h1);
         chk("oob status", st, 32'h3);
      end
      apb(1'b1, 8'h04, 32'h0020_0007);
      n0 = nreq;
      look(32'h03FF_F000);
      chk("pp entry", lreq.addr, 32'h0020_FFFC);
      look(32'h0400_0000);
      chk("pp aperture", nreq - n0, 32'h1);
      apb(1'b1, 8'h04, 32'h0);
      // a write during a slow lookup is refused
      slow <= 1'b1;
      apb(1'b1, 8'h1C, 32'h0000_5000);
      apb(1'b1, 8'h00, 32'h0);
      chk("busy write", e, 32'h1);
      do apb(1'b0, 8'h24, 32'h0); while (r[3] !== 1'b0);
      slow <= 1'b0;
      rdc(8'h00, 32'h0010_0004);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 8'h0C, pt[i][0]);
         apb(1'b1, 8'h10, pt[i][1]);
         apb(1'b1, 8'h14, pt[i][2]);
         apb(1'b1, 8'h18, pt[i][3]);
         apb(1'b0, 8'h24, 32'h0);
         chk("placement", r[2], pt[i][4]);
         chk("batch addr", lreq.addr, pt[i][2] & 32'hFFFF_FFF8);
         chk("batch kind", {lreq.write, lreq.snoop}, 32'h0);
      end
      apb(1'b0, 8'h34, 32'h0);
      chk("unmapped", e, 32'h1);
      print_verdict();
   end
endmodule
